// ### pkg/aea_params.svh
`ifndef AEA_PARAMS_SVH
`define AEA_PARAMS_SVH

// ==========================================================
// Clock and timing
`define AEA_CLOCK_HZ        40000000
`define AEA_STEP_CYCLES     2'd3
`define AEA_LPF_CORNER_HZ   8.9
`define AEA_RATE0_SPS       27900
`define AEA_RATE1_SPS       14000
`define AEA_RATE2_SPS       7000
`define AEA_RATE3_SPS       3500

// ==========================================================
// Datapath widths and scaling
`define AEA_SAMPLE_W        20
`define AEA_ENERGY_W        40
`define AEA_ACC_W           48
`define AEA_POWER_W         32
`define AEA_WAVE_W          24
`define AEA_LPF_FRAC_W      24
`define AEA_GAIN_UNITY      14'h1000
`define AEA_SCALE_LSB       22
`define AEA_FIFO_DEPTH      8

// ==========================================================
// Register offsets on the register port
`define AEA_REG_WAVEFORM    4'h1
`define AEA_REG_ENERGY      4'h2
`define AEA_REG_MODE        4'h3
`define AEA_REG_IRQ_EN      4'h4
`define AEA_REG_IRQ_STATUS  4'h5
`define AEA_REG_POWER_GAIN  4'h6
`define AEA_REG_POWER_OFFS  4'h7

// ==========================================================
// Field positions
`define AEA_MODE_RATE_LSB   11
`define AEA_MODE_RATE_MSB   12
`define AEA_MODE_WAVE_LSB   13
`define AEA_MODE_WAVE_MSB   14
`define AEA_IRQ_HALF        0
`define AEA_IRQ_WRAP        1
`define AEA_IRQ_SAMPLE      3

// ==========================================================
// Reset values
`define AEA_MODE_RESET      16'h0000
`define AEA_IRQ_EN_RESET    4'h0
`define AEA_GAIN_RESET      12'h000
`define AEA_OFFSET_RESET    16'h0000

`endif

// ### pkg/aea_pkg.sv
package aea_pkg;
`include "aea_params.svh"

   typedef struct packed {
      logic [3:0]  addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } aea_reg_req_t;

   typedef struct packed {
      logic        rvalid;
      logic [39:0] rdata;
   } aea_reg_rsp_t;

   typedef enum {
      AEA_WAVE_COUNT,
      AEA_WAVE_HOLD
   } aea_wave_state_t;

endpackage

// ### hw/aea_fifo.sv
`timescale 1ns/1ps
`include "aea_params.svh"

module aea_fifo #(
   parameter int WIDTH = `AEA_WAVE_W,
   parameter int DEPTH = `AEA_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             ce,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic [PW-1:0]    next_wr_ptr;
   logic [PW-1:0]    next_rd_ptr;
   logic [CW-1:0]    next_count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != CW'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (ce) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // ==========================================================
   // Storage, one register per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clock) begin
         if (ce && push && wr_ptr == PW'(i)) begin
            mem[i] <= in_data;
         end
      end
   end

endmodule

// ### hw/aea_active_energy.sv
// Operation
// R1 - Multiply current and voltage samples per step
// R2 - Lowpass product to obtain active power
// R3 - Gain 800h gives smallest, 7FFh largest range
// R4 - Accumulate power into 40-bit energy, gapless
// R5 - One accumulation step every four clocks
// R6 - Signed add; negative power lowers energy
// R7 - Host selects power waveform and sample enable
// R8 - Waveform rates 27.9, 14, 7, 3.5 kSPS
// R9 - Positive overflow wraps to full-scale negative
// R10 - Negative underflow wraps to full-scale positive
// R11 - Interrupt on half-full energy, either sign
// R12 - Interrupt on energy overflow or underflow
// R13 - Signed 16-bit offset added before accumulation
// R14 - Offset 256 equals one waveform LSB
// R15 - Full-scale sine power averages CCCD
// R16 - Power scaled by one plus gain/4096
// R17 - Mode bits 12:11 pick sample rate
// R18 - New waveform sample drives interrupt low
// R19 - First-order lowpass corner at 8.9 Hz
`timescale 1ns/1ps
`include "aea_params.svh"

module aea_active_energy (
   // Clock and reset
   input  wire logic                             clock,
   input  wire logic                             rst,
   input  wire logic                             ce,
   // ADC samples, same clock domain
   input  wire logic signed [`AEA_SAMPLE_W-1:0]  current_sample,
   input  wire logic signed [`AEA_SAMPLE_W-1:0]  voltage_sample,
   // Register port
   input  wire aea_pkg::aea_reg_req_t            reg_req,
   output aea_pkg::aea_reg_rsp_t                 reg_rsp,
   // Interrupt request
   output logic                                  irq_n
);
   localparam int LPF_COEF = int'(2.0 * 3.14159265 * `AEA_LPF_CORNER_HZ
                                  / (`AEA_CLOCK_HZ / 4.0) * (2.0 ** `AEA_LPF_FRAC_W));

   function automatic logic [13:0] rate_count(input logic [1:0] sel);
      logic [13:0] n;
      n = 14'(`AEA_CLOCK_HZ / `AEA_RATE0_SPS);
      case (sel)
         2'h1:    n = 14'(`AEA_CLOCK_HZ / `AEA_RATE1_SPS);
         2'h2:    n = 14'(`AEA_CLOCK_HZ / `AEA_RATE2_SPS);
         2'h3:    n = 14'(`AEA_CLOCK_HZ / `AEA_RATE3_SPS);
         default: n = 14'(`AEA_CLOCK_HZ / `AEA_RATE0_SPS);
      endcase
      return n - 14'h0001;
   endfunction

   // ==========================================================
   // State
   logic        [1:0]                    step_count;
   logic signed [`AEA_POWER_W+23:0]      lpf_state;
   logic signed [`AEA_ACC_W-1:0]         energy_full;
   logic        [15:0]                   mode;
   logic        [3:0]                    irq_en;
   logic        [3:0]                    status;
   logic        [11:0]                   power_gain;
   logic        [15:0]                   power_offset;
   aea_pkg::aea_wave_state_t             wave_state;
   logic        [13:0]                   wave_count;
   logic        [`AEA_WAVE_W-1:0]        wave_word;

   logic        [1:0]                    next_step_count;
   logic signed [`AEA_POWER_W+23:0]      next_lpf_state;
   logic signed [`AEA_ACC_W-1:0]         next_energy_full;
   logic        [15:0]                   next_mode;
   logic        [3:0]                    next_irq_en;
   logic        [3:0]                    next_status;
   logic        [11:0]                   next_power_gain;
   logic        [15:0]                   next_power_offset;
   aea_pkg::aea_wave_state_t             next_wave_state;
   logic        [13:0]                   next_wave_count;
   logic        [`AEA_WAVE_W-1:0]        next_wave_word;
   aea_pkg::aea_reg_rsp_t                next_reg_rsp;
   logic                                 next_irq_n;

   // ==========================================================
   // Power datapath
   logic                                 step_fire;
   logic signed [39:0]                   product;
   logic signed [13:0]                   gain_factor;
   logic signed [53:0]                   scaled;
   logic signed [`AEA_POWER_W-1:0]       inst_power;
   logic signed [`AEA_POWER_W-1:0]       power_q8;
   logic signed [`AEA_POWER_W:0]         lpf_diff;
   logic signed [41:0]                   lpf_delta;
   logic signed [`AEA_ACC_W-1:0]         addend;
   logic signed [`AEA_ACC_W-1:0]         energy_sum;
   logic                                 wrap_up;
   logic                                 wrap_down;
   logic                                 half_reached;
   logic                                 wave_enabled;
   logic                                 fifo_in_ready;
   logic                                 fifo_out_valid;
   logic        [`AEA_WAVE_W-1:0]        fifo_out_data;
   logic                                 wave_pop;
   logic                                 sample_pushed;
   logic                                 wr_hit;

   assign step_fire   = ce && (step_count == `AEA_STEP_CYCLES); // R5
   assign product     = current_sample * voltage_sample; // R1
   // Gain word is signed, so 800h gives half and 7FFh about 1.5 times unity
   assign gain_factor = $signed(`AEA_GAIN_UNITY) + $signed({{2{power_gain[11]}}, power_gain}); // R3 R16
   assign scaled      = product * gain_factor;
   // Drops the gain fraction and the product scale; keeps 8 bits below a waveform LSB
   assign inst_power  = scaled[`AEA_SCALE_LSB+`AEA_POWER_W-1:`AEA_SCALE_LSB]; // R15
   assign power_q8    = lpf_state[`AEA_POWER_W+23:24];
   assign lpf_diff    = {inst_power[`AEA_POWER_W-1], inst_power} - {power_q8[`AEA_POWER_W-1], power_q8};
   assign lpf_delta   = lpf_diff * $signed({1'b0, 8'(LPF_COEF)}); // R19
   // Offset sits at the 1/256 position, so 0100h is one waveform LSB
   assign addend      = `AEA_ACC_W'(power_q8) + `AEA_ACC_W'($signed(power_offset)); // R13 R14
   assign energy_sum  = energy_full + addend; // R6
   assign wrap_up     = !addend[`AEA_ACC_W-1] && !energy_full[`AEA_ACC_W-1] && energy_sum[`AEA_ACC_W-1]; // R9
   assign wrap_down   = addend[`AEA_ACC_W-1] && energy_full[`AEA_ACC_W-1] && !energy_sum[`AEA_ACC_W-1]; // R10
   assign half_reached = (energy_sum[`AEA_ACC_W-1] ^ energy_sum[`AEA_ACC_W-2])
                       && !(energy_full[`AEA_ACC_W-1] ^ energy_full[`AEA_ACC_W-2]); // R11
   assign wave_enabled = (mode[`AEA_MODE_WAVE_MSB:`AEA_MODE_WAVE_LSB] == 2'h0)
                       && irq_en[`AEA_IRQ_SAMPLE]; // R7
   assign wave_pop     = ce && reg_req.rd && (reg_req.addr == `AEA_REG_WAVEFORM) && fifo_out_valid;
   assign sample_pushed = ce && (wave_state == aea_pkg::AEA_WAVE_HOLD) && fifo_in_ready;
   assign wr_hit       = ce && reg_req.wr;

   // ==========================================================
   // Accumulation
   always_comb begin
      next_step_count  = step_count + 2'h1; // R5
      next_lpf_state   = lpf_state;
      next_energy_full = energy_full;
      if (step_fire) begin
         next_lpf_state   = lpf_state + {{14{lpf_delta[41]}}, lpf_delta}; // R2
         next_energy_full = energy_sum; // R4 R6
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         step_count  <= 2'h0;
         lpf_state   <= '0;
         energy_full <= '0;
      end else if (ce) begin
         step_count  <= next_step_count;
         lpf_state   <= next_lpf_state;
         energy_full <= next_energy_full;
      end
   end

   // ==========================================================
   // Waveform sampler; a full buffer holds the sample and stops the rate count
   always_comb begin
      next_wave_state = wave_state;
      next_wave_count = wave_count;
      next_wave_word  = wave_word;
      case (wave_state)
         aea_pkg::AEA_WAVE_COUNT: begin
            if (!wave_enabled) begin
               next_wave_count = rate_count(mode[`AEA_MODE_RATE_MSB:`AEA_MODE_RATE_LSB]);
            end else if (wave_count == 14'h0000) begin
               next_wave_count = rate_count(mode[`AEA_MODE_RATE_MSB:`AEA_MODE_RATE_LSB]); // R8 R17
               next_wave_word  = power_q8[`AEA_WAVE_W+7:8];
               next_wave_state = aea_pkg::AEA_WAVE_HOLD;
            end else begin
               next_wave_count = wave_count - 14'h0001;
            end
         end
         aea_pkg::AEA_WAVE_HOLD: begin
            if (fifo_in_ready) begin
               next_wave_state = aea_pkg::AEA_WAVE_COUNT;
            end
         end
         default: next_wave_state = aea_pkg::AEA_WAVE_COUNT;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wave_state <= aea_pkg::AEA_WAVE_COUNT;
         wave_count <= 14'h0000;
         wave_word  <= '0;
      end else if (ce) begin
         wave_state <= next_wave_state;
         wave_count <= next_wave_count;
         wave_word  <= next_wave_word;
      end
   end

   aea_fifo #(
      .WIDTH (`AEA_WAVE_W),
      .DEPTH (`AEA_FIFO_DEPTH)
   ) u_wave_fifo (
      .clock     (clock),
      .rst       (rst),
      .ce        (ce),
      .in_valid  (wave_state == aea_pkg::AEA_WAVE_HOLD),
      .in_ready  (fifo_in_ready),
      .in_data   (wave_word),
      .out_valid (fifo_out_valid),
      .out_ready (wave_pop),
      .out_data  (fifo_out_data)
   );

   // ==========================================================
   // Registers, status and interrupt
   always_comb begin
      next_mode         = mode;
      next_irq_en       = irq_en;
      next_power_gain   = power_gain;
      next_power_offset = power_offset;
      next_status       = status;
      next_reg_rsp      = '0;
      if (wr_hit) begin
         if (reg_req.addr == `AEA_REG_MODE) begin
            next_mode = reg_req.wdata;
         end else if (reg_req.addr == `AEA_REG_IRQ_EN) begin
            next_irq_en = {reg_req.wdata[3], 1'b0, reg_req.wdata[1:0]};
         end else if (reg_req.addr == `AEA_REG_POWER_GAIN) begin
            next_power_gain = reg_req.wdata[11:0];
         end else if (reg_req.addr == `AEA_REG_POWER_OFFS) begin
            next_power_offset = reg_req.wdata;
         end
      end
      if (ce && reg_req.rd) begin
         next_reg_rsp.rvalid = 1'b1;
         if (reg_req.addr == `AEA_REG_WAVEFORM) begin
            next_reg_rsp.rdata = 40'(fifo_out_data);
         end else if (reg_req.addr == `AEA_REG_ENERGY) begin
            next_reg_rsp.rdata = energy_full[`AEA_ACC_W-1:`AEA_ACC_W-`AEA_ENERGY_W];
         end else if (reg_req.addr == `AEA_REG_MODE) begin
            next_reg_rsp.rdata = 40'(mode);
         end else if (reg_req.addr == `AEA_REG_IRQ_EN) begin
            next_reg_rsp.rdata = 40'(irq_en);
         end else if (reg_req.addr == `AEA_REG_IRQ_STATUS) begin
            next_reg_rsp.rdata = 40'(status);
            next_status        = 4'h0;
         end else if (reg_req.addr == `AEA_REG_POWER_GAIN) begin
            next_reg_rsp.rdata = 40'(power_gain);
         end else if (reg_req.addr == `AEA_REG_POWER_OFFS) begin
            next_reg_rsp.rdata = 40'(power_offset);
         end
      end
      // New events win over a status read in the same cycle
      if (step_fire && half_reached) begin
         next_status[`AEA_IRQ_HALF] = 1'b1; // R11
      end
      if (step_fire && (wrap_up || wrap_down)) begin
         next_status[`AEA_IRQ_WRAP] = 1'b1; // R12
      end
      if (sample_pushed) begin
         next_status[`AEA_IRQ_SAMPLE] = 1'b1; // R18
      end
      // Use the enable as it will stand after this edge, so a fresh enable of a set bit is not one cycle late
      next_irq_n = !(|(next_status & next_irq_en)); // R11 R12 R18
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         mode         <= `AEA_MODE_RESET;
         irq_en       <= `AEA_IRQ_EN_RESET;
         power_gain   <= `AEA_GAIN_RESET;
         power_offset <= `AEA_OFFSET_RESET;
         status       <= 4'h0;
         reg_rsp      <= '0;
         irq_n        <= 1'b1;
      end else if (ce) begin
         mode         <= next_mode;
         irq_en       <= next_irq_en;
         power_gain   <= next_power_gain;
         power_offset <= next_power_offset;
         status       <= next_status;
         reg_rsp      <= next_reg_rsp;
         irq_n        <= next_irq_n;
      end
   end

   // ==========================================================
   // Checks
   property p_step_spacing;
      @(posedge clock) disable iff (rst)
      step_fire |=> !step_fire [*3];
   endproperty
   a_step_spacing: assert property (p_step_spacing) else $error("steps closer than four clocks"); // R5

   property p_energy_only_on_step;
      @(posedge clock) disable iff (rst)
      !step_fire |=> $stable(energy_full);
   endproperty
   a_energy_only_on_step: assert property (p_energy_only_on_step) else $error("energy moved off step"); // R4

   property p_signed_add;
      @(posedge clock) disable iff (rst)
      step_fire |=> energy_full == $past(energy_full) + $past(addend);
   endproperty
   a_signed_add: assert property (p_signed_add) else $error("energy step is not a signed add"); // R6

   property p_wrap_up_flag;
      @(posedge clock) disable iff (rst)
      step_fire && wrap_up |=> energy_full[`AEA_ACC_W-1] && status[`AEA_IRQ_WRAP];
   endproperty
   a_wrap_up_flag: assert property (p_wrap_up_flag) else $error("overflow not wrapped or flagged"); // R9

   property p_wrap_down_flag;
      @(posedge clock) disable iff (rst)
      step_fire && wrap_down |=> !energy_full[`AEA_ACC_W-1] && status[`AEA_IRQ_WRAP];
   endproperty
   a_wrap_down_flag: assert property (p_wrap_down_flag) else $error("underflow not wrapped or flagged"); // R10

   property p_half_flag;
      @(posedge clock) disable iff (rst)
      step_fire && half_reached |=> status[`AEA_IRQ_HALF];
   endproperty
   a_half_flag: assert property (p_half_flag) else $error("half-full not flagged"); // R11

   property p_irq_follows;
      @(posedge clock) disable iff (rst)
      ce ##1 (|(status & irq_en)) |-> !irq_n;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("enabled event without interrupt"); // R12 R18

   property p_rate_field;
      @(posedge clock) disable iff (rst)
      wr_hit && reg_req.addr == `AEA_REG_MODE |=>
         mode[`AEA_MODE_RATE_MSB:`AEA_MODE_RATE_LSB] == $past(reg_req.wdata[12:11]);
   endproperty
   a_rate_field: assert property (p_rate_field) else $error("rate select not stored"); // R17

   property p_sample_irq;
      @(posedge clock) disable iff (rst)
      sample_pushed && next_irq_en[`AEA_IRQ_SAMPLE] |=> !irq_n;
   endproperty
   a_sample_irq: assert property (p_sample_irq) else $error("sample without interrupt"); // R18

endmodule

// ### bench/aea_host_model.sv
`timescale 1ns/1ps

// ==========================================
// Host side of the register port
module aea_host_model (
   // Clock
   input  wire logic                  clock,
   // Register port
   output aea_pkg::aea_reg_req_t      reg_req,
   input  wire aea_pkg::aea_reg_rsp_t reg_rsp
);
   initial reg_req = '0;

   // Released lines flip so a stale copy never passes for a value
   task automatic idle();
      reg_req.wr    = 1'b0;
      reg_req.rd    = 1'b0;
      reg_req.addr  = ~reg_req.addr;
      reg_req.wdata = ~reg_req.wdata;
   endtask

   task automatic write(input logic [3:0] a, input logic [15:0] x);
      @(negedge clock);
      reg_req.addr  = a;
      reg_req.wdata = x;
      reg_req.wr    = 1'b1;
      @(negedge clock);
      idle();
   endtask

   task automatic read(input logic [3:0] a, output logic [39:0] x);
      @(negedge clock);
      reg_req.addr = a;
      reg_req.rd   = 1'b1;
      @(negedge clock);
      x = (reg_rsp.rvalid === 1'b1) ? reg_rsp.rdata : 'x;
      idle();
   endtask
endmodule

// ### bench/aea_active_energy_tb.sv
`timescale 1ns/1ps
`include "aea_params.svh"

module aea_active_energy_tb;
   logic                            clock;
   logic                            rst;
   logic                            ce;
   logic signed [`AEA_SAMPLE_W-1:0] current_sample;
   logic signed [`AEA_SAMPLE_W-1:0] voltage_sample;
   aea_pkg::aea_reg_req_t           reg_req;
   aea_pkg::aea_reg_rsp_t           reg_rsp;
   logic                            irq_n;
   int                              n_mismatch;
   int                              n_tests;
   int                              cyc = 0;
   int                              t0;
   logic        [39:0]              d;
   logic signed [39:0]              e [4];

   localparam logic [3:0]  RW_A [6] = '{`AEA_REG_ENERGY, `AEA_REG_POWER_GAIN, `AEA_REG_POWER_GAIN,
                                       `AEA_REG_POWER_OFFS, `AEA_REG_IRQ_EN, `AEA_REG_MODE};
   localparam logic [15:0] RW_D [6] = '{16'h1234, 16'h07ff, 16'h0800, 16'h8001, 16'hffff, 16'h1800};
   localparam logic [15:0] RW_X [6] = '{16'h0000, 16'h07ff, 16'h0800, 16'h8001, 16'h000b, 16'h1800};
   localparam logic [15:0] OF_D [4] = '{16'h0100, 16'h0080, 16'hff00, 16'h0000};
   localparam logic [39:0] OF_X [4] = '{40'h64, 40'h32, 40'hff_ffff_ff9c, 40'h0};
   localparam logic [15:0] GN_D [4] = '{16'h0800, 16'h0000, 16'h07ff, 16'h0000};
   localparam int          RATE_N [4] = '{1433, 2857, 5714, 11428};

   aea_active_energy i_aea_active_energy (.clock(clock), .rst(rst), .ce(ce), .current_sample(current_sample),
      .voltage_sample(voltage_sample), .reg_req(reg_req), .reg_rsp(reg_rsp), .irq_n(irq_n));
   aea_host_model i_aea_host_model (.clock(clock), .reg_req(reg_req), .reg_rsp(reg_rsp));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // ==========================================
   // Shared tasks
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [39:0] s, input logic [39:0] x);
      n_tests++;
      if (s !== x) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask

   task automatic rd(input logic [3:0] a);
      i_aea_host_model.read(a, d);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] x);
      i_aea_host_model.write(a, x);
   endtask

   task automatic reset_dut();
      @(negedge clock);
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
   endtask

   // Two energy reads taken k + 2 cycles apart; the enable is low for the first off of them
   task automatic energy_step(input int k, input int off, output logic [39:0] df);
      logic [39:0] a;
      rd(`AEA_REG_ENERGY);
      a = d;
      if (off > 0) begin
         ce = 1'b0;
         repeat (off) @(negedge clock);
         ce = 1'b1;
      end
      repeat (k - off) @(negedge clock);
      rd(`AEA_REG_ENERGY);
      df = d - a;
   endtask

   task automatic wait_fall();
      for (int i = 0; i < 12000 && irq_n !== 1'b0; i++) @(negedge clock);
   endtask

   task automatic clear_pop();
      rd(`AEA_REG_IRQ_STATUS);
      rd(`AEA_REG_WAVEFORM);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_regs();
      reset_dut();
      for (int i = 0; i < 16; i++) begin
         rd(4'(i));
         if (i != 1) check(d, 40'h0);
      end
      for (int i = 0; i < 6; i++) begin
         wr(RW_A[i], RW_D[i]);
         rd(RW_A[i]);
         check(d, {24'h0, RW_X[i]});
      end
   endtask

   // Samples stay zero, so only the offset feeds the accumulator
   task automatic t_offset();
      logic [39:0] df;
      reset_dut();
      for (int i = 0; i < 4; i++) begin
         wr(`AEA_REG_POWER_OFFS, OF_D[i]);
         repeat (8) @(negedge clock);
         energy_step(398, 0, df);
         check(df, OF_X[i]);
      end
      // Frozen cycles must not count toward the four-clock step
      wr(`AEA_REG_POWER_OFFS, 16'h0100);
      energy_step(398, 200, df);
      check(df, 40'h32);
   endtask

   task automatic t_gain();
      for (int i = 0; i < 4; i++) begin
         reset_dut();
         wr(`AEA_REG_POWER_GAIN, GN_D[i]);
         current_sample = (i == 3) ? -20'sh7ffff : 20'sh7ffff;
         voltage_sample = 20'sh7ffff;
         repeat (4000) @(negedge clock);
         rd(`AEA_REG_ENERGY);
         e[i] = d;
         current_sample = '0;
         voltage_sample = '0;
      end
      check(e[0] > 0, 1'b1);
      check(e[1] > e[0] && e[2] > e[1], 1'b1);
      check(2 * e[2] > 5 * e[0] && 2 * e[2] < 7 * e[0], 1'b1);
      check(e[3] < 0, 1'b1);
   endtask

   // A full queue must stall the sampler until a word is popped
   task automatic t_fifo();
      reset_dut();
      wr(`AEA_REG_IRQ_EN, 16'h0008);
      wr(`AEA_REG_MODE, 16'h0000);
      repeat (12000) @(negedge clock);
      check(irq_n, 1'b0);
      rd(`AEA_REG_IRQ_STATUS);
      repeat (1600) @(negedge clock);
      rd(`AEA_REG_IRQ_STATUS);
      check(d[3], 1'b0);
      check(irq_n, 1'b1);
      rd(`AEA_REG_WAVEFORM);
      check(d, 40'h0);
      repeat (1600) @(negedge clock);
      rd(`AEA_REG_IRQ_STATUS);
      check(d[3], 1'b1);
      // Samples stayed zero since reset, so every queued word is zero
      for (int i = 0; i < 9; i++) begin
         rd(`AEA_REG_WAVEFORM);
         check(d, 40'h0);
      end
   endtask

   task automatic t_rates();
      for (int r = 0; r < 4; r++) begin
         wr(`AEA_REG_MODE, 16'(r << 11));
         clear_pop();
         wait_fall();
         t0 = cyc;
         clear_pop();
         wait_fall();
         check(cyc - t0 >= RATE_N[r] - 1 && cyc - t0 <= RATE_N[r] + 1, 1'b1);
      end
      // Another waveform mode, then a clear sample enable, must queue nothing
      wr(`AEA_REG_MODE, 16'h2000);
      rd(`AEA_REG_IRQ_STATUS);
      repeat (3000) @(negedge clock);
      rd(`AEA_REG_IRQ_STATUS);
      check(d[3], 1'b0);
      wr(`AEA_REG_MODE, 16'h0000);
      wr(`AEA_REG_IRQ_EN, 16'h0000);
      rd(`AEA_REG_IRQ_STATUS);
      repeat (3000) @(negedge clock);
      check(irq_n, 1'b1);
      rd(`AEA_REG_IRQ_STATUS);
      check(d[3], 1'b0);
   endtask

   // ==========================================
   // Main sequence and hang guard
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      current_sample = '0;
      voltage_sample = '0;
      n_mismatch = 0;
      n_tests = 0;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      t_regs();
      t_offset();
      t_gain();
      t_fifo();
      t_rates();
      finish_test();
   end

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         n_mismatch++;
         finish_test();
      end
   end
endmodule
